// ### lcia_target.sv
// Purpose: Target end: address matching, control byte and pointer advance
// Assumes: Link wires sampled on clk_in, no clock stretching
// Notes:   Holds its own copy of the thirteen byte registers
`timescale 1ns/1ps
module lcia_target
   import lcia_pkg::*;
#(
   parameter logic       TEN_PIN      = 1'b1,             // Ten-pin variant
   parameter logic [6:0] REGULAR_BASE = REGULAR_BASE_DEF  // Regular address
)(
   input  wire logic       clk_in,                   // System clock
   input  wire logic       rst_b_in,                 // Async reset, low
   lcia_if.target          bus,                      // Link wires
   input  wire logic       address_select_pin_0_in,  // Select pin 0
   input  wire logic       address_select_pin_1_in,  // Select pin 1
   output logic            reg_wr_pulse_out,         // Register written
   output logic [3:0]      reg_wr_index_out,         // Written index
   output logic [7:0]      reg_wr_data_out,          // Written byte
   output logic [7:0]      control_byte_out,         // Control register
   output logic            software_reset_call_out,  // Reset call seen
   output logic            transfer_active_out       // From START until STOP or T_IGNORE
);
   typedef enum logic [2:0] {
      T_IDLE, T_ADDR, T_CTRL, T_WDATA, T_ACK, T_RDATA, T_MACK, T_IGNORE
   } lcia_tgt_state_e;

   lcia_tgt_state_e st_r;
   lcia_tgt_state_e ack_next_r;
   logic [2:0]      scl_sync_r;
   logic [2:0]      sda_sync_r;
   logic [1:0]      pin_sync1_r;
   logic [1:0]      pin_sync2_r;
   logic [3:0]      cnt_r;
   logic [7:0]      shift_r;
   logic [7:0]      tx_r;
   logic [7:0]      ctrl_r;
   logic [7:0]      regs_r [0:NUM_REGS-1];
   logic            sda_oe_r;
   logic            nack_r;
   logic            scl_rise;
   logic            scl_fall;
   logic            start_det;
   logic            stop_det;
   logic            byte_done;
   logic            addr_hit;
   logic            is_software_reset_call;
   logic            ctrl_ok;
   logic            ev_ctrl;
   logic            ev_data;
   logic            ev_read;
   logic [6:0]      regular_addr;
   logic [7:0]      mode1;
   logic [7:0]      rd_byte;
   logic [3:0]      ptr_next;

   assign bus.sda_o_tgt    = 1'b0;
   assign bus.sda_oe_tgt   = sda_oe_r;
   assign control_byte_out = ctrl_r;

   // Only stage 1 and 2 form the synchroniser; stage 2 and 3 give edges
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_sync_r  <= 3'h7;
         sda_sync_r  <= 3'h7;
         pin_sync1_r <= 2'h0;
         pin_sync2_r <= 2'h0;
      end else begin
         scl_sync_r  <= {scl_sync_r[1:0], bus.scl};
         sda_sync_r  <= {sda_sync_r[1:0], bus.sda};
         pin_sync1_r <= {address_select_pin_1_in, address_select_pin_0_in};
         pin_sync2_r <= pin_sync1_r;
      end
   end

   always_comb begin
      scl_rise  = scl_sync_r[1] & ~scl_sync_r[2];
      scl_fall  = ~scl_sync_r[1] & scl_sync_r[2];
      start_det = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[1] & sda_sync_r[2];
      stop_det  = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[1] & ~sda_sync_r[2];
      byte_done = scl_fall & (cnt_r == 4'h8);
      regular_addr = TEN_PIN ? {REGULAR_BASE[6:2], pin_sync2_r} : REGULAR_BASE;
      mode1     = regs_r[IDX_MODE1];
      is_software_reset_call  = (shift_r == SOFTWARE_RESET_CALL_BYTE);
      addr_hit  = (shift_r[7:1] == regular_addr)
                | (mode1[GROUP_EN_BIT] & (shift_r[7:1] == regs_r[IDX_GROUP][7:1]))
                | (mode1[SUB_CALL_1_ENABLE_EN_BIT] & (shift_r[7:1] == regs_r[IDX_SUB_CALL_1_ENABLE][7:1]))
                | (mode1[SUB_CALL_2_ENABLE_EN_BIT] & (shift_r[7:1] == regs_r[IDX_SUB_CALL_2_ENABLE][7:1]))
                | (mode1[SUB_CALL_3_ENABLE_EN_BIT] & (shift_r[7:1] == regs_r[IDX_SUB_CALL_3_ENABLE][7:1]))
                | is_software_reset_call;
      ctrl_ok   = (shift_r[3:0] <= PTR_LAST);
      ev_ctrl   = (st_r == T_CTRL) & byte_done & ctrl_ok & ~start_det & ~stop_det;
      ev_data   = (st_r == T_WDATA) & byte_done & ~start_det & ~stop_det;
      ev_read   = (st_r == T_RDATA) & scl_fall & (cnt_r == 4'h7) & ~start_det & ~stop_det;
      // Option bits of the control byte read back through mode register 1
      rd_byte   = (ctrl_r[3:0] == IDX_MODE1) ? {ctrl_r[7:5], mode1[4:0]} : regs_r[ctrl_r[3:0]];
   end

   lcia_ptr_step u_step (
      .ptr_in    (ctrl_r[3:0]),
      .option_in (ctrl_r[7:5]),
      .ptr_out   (ptr_next)
   );

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r       <= T_IDLE;
         ack_next_r <= T_IDLE;
         cnt_r      <= 4'h0;
         shift_r    <= 8'h00;
         tx_r       <= 8'h00;
         sda_oe_r   <= 1'b0;
         nack_r     <= 1'b0;
      end else if (stop_det) begin
         st_r     <= T_IDLE;
         sda_oe_r <= 1'b0;
      end else if (start_det) begin
         st_r     <= T_ADDR;
         cnt_r    <= 4'h0;
         sda_oe_r <= 1'b0;
      end else begin
         unique case (st_r)
            T_IDLE, T_IGNORE: begin
               sda_oe_r <= 1'b0;
            end
            T_ADDR, T_CTRL, T_WDATA: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_sync_r[1]};
                  cnt_r   <= cnt_r + 4'h1;
               end else if (byte_done) begin
                  cnt_r <= 4'h0;
                  if (st_r == T_ADDR) begin
                     if (addr_hit) begin
                        sda_oe_r <= 1'b1;
                        st_r     <= T_ACK;
                        if (is_software_reset_call) begin
                           ack_next_r <= T_IGNORE;
                        end else if (shift_r[0]) begin
                           ack_next_r <= T_RDATA;
                        end else begin
                           ack_next_r <= T_CTRL;
                        end
                     end else begin
                        st_r <= T_IGNORE;
                     end
                  end else if (st_r == T_CTRL && !ctrl_ok) begin
                     st_r <= T_IGNORE;
                  end else begin
                     sda_oe_r   <= 1'b1;
                     st_r       <= T_ACK;
                     ack_next_r <= T_WDATA;
                  end
               end
            end
            T_ACK: begin
               if (scl_fall) begin
                  cnt_r <= 4'h0;
                  st_r  <= ack_next_r;
                  if (ack_next_r == T_RDATA) begin
                     tx_r     <= rd_byte;
                     sda_oe_r <= ~rd_byte[7];
                  end else begin
                     sda_oe_r <= 1'b0;
                  end
               end
            end
            T_RDATA: begin
               if (scl_fall) begin
                  if (cnt_r == 4'h7) begin
                     sda_oe_r <= 1'b0;
                     st_r     <= T_MACK;
                  end else begin
                     tx_r     <= {tx_r[6:0], 1'b0};
                     sda_oe_r <= ~tx_r[6];
                     cnt_r    <= cnt_r + 4'h1;
                  end
               end
            end
            T_MACK: begin
               if (scl_rise) begin
                  nack_r <= sda_sync_r[1];
               end else if (scl_fall) begin
                  if (nack_r) begin
                     st_r <= T_IGNORE;
                  end else begin
                     tx_r     <= rd_byte;
                     sda_oe_r <= ~rd_byte[7];
                     cnt_r    <= 4'h0;
                     st_r     <= T_RDATA;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_r <= CTRL_RESET;
      end else if (ev_ctrl) begin
         ctrl_r <= shift_r;
      end else if (ev_data || ev_read) begin
         ctrl_r[3:0] <= ptr_next;
      end
   end

   // Option bits of mode register 1 are read-only copies, never stored
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_r[i] <= REG_RESET[i];
         end
      end else if (ev_data) begin
         if (ctrl_r[3:0] == IDX_MODE1) begin
            regs_r[IDX_MODE1] <= {3'h0, shift_r[4:0]};
         end else begin
            regs_r[ctrl_r[3:0]] <= shift_r;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_wr_pulse_out        <= 1'b0;
         reg_wr_index_out        <= 4'h0;
         reg_wr_data_out         <= 8'h00;
         software_reset_call_out <= 1'b0;
         transfer_active_out     <= 1'b0;
      end else begin
         reg_wr_pulse_out        <= ev_data;
         software_reset_call_out <= (st_r == T_ADDR) & byte_done & is_software_reset_call & ~start_det & ~stop_det;
         transfer_active_out     <= (st_r != T_IDLE) && (st_r != T_IGNORE);
         if (ev_data) begin
            reg_wr_index_out <= ctrl_r[3:0];
            reg_wr_data_out  <= shift_r;
         end
      end
   end
endmodule

// ### lcia_pkg.sv
// Purpose: Constants shared by both ends of the LED driver address and pointer link
// Assumes: 40 MHz system clock on both ends
// Notes:   Register indices are 4-bit pointer values
package lcia_pkg;
   localparam int          CLK_PERIOD_NS   = 25;
   localparam int          SCL_QUARTER_NS  = 2500;
   localparam logic [7:0]  SCL_QUARTER_CYC = 8'((SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam int          NUM_REGS        = 13;
   localparam logic [3:0]  PTR_FIRST       = 4'h0;
   localparam logic [3:0]  PTR_LAST        = 4'hC;
   localparam logic [3:0]  BRIGHT_FIRST    = 4'h2;
   localparam logic [3:0]  BRIGHT_LAST     = 4'h5;
   localparam logic [3:0]  GROUPREG_FIRST  = 4'h6;
   localparam logic [3:0]  GROUPREG_LAST   = 4'h7;
   localparam logic [3:0]  IDX_MODE1       = 4'h0;
   localparam logic [3:0]  IDX_SUB_CALL_1_ENABLE        = 4'h9;
   localparam logic [3:0]  IDX_SUB_CALL_2_ENABLE        = 4'hA;
   localparam logic [3:0]  IDX_SUB_CALL_3_ENABLE        = 4'hB;
   localparam logic [3:0]  IDX_GROUP       = 4'hC;

   localparam int          INC_EN_POS      = 2;   // Within the 3-bit option
   localparam int          SUB_CALL_1_ENABLE_EN_BIT     = 3;
   localparam int          SUB_CALL_2_ENABLE_EN_BIT     = 2;
   localparam int          SUB_CALL_3_ENABLE_EN_BIT     = 1;
   localparam int          GROUP_EN_BIT    = 0;

   localparam logic [2:0]  OPT_ALL         = 3'h4;
   localparam logic [2:0]  OPT_BRIGHT      = 3'h5;
   localparam logic [2:0]  OPT_GROUPREG    = 3'h6;
   localparam logic [2:0]  OPT_BOTH        = 3'h7;

   localparam logic [7:0]  SOFTWARE_RESET_CALL_BYTE      = 8'h06;
   localparam logic [6:0]  REGULAR_BASE_DEF = 7'h62; // Arbitrary value
   localparam logic [7:0]  CTRL_RESET      = 8'h00;

   localparam logic [7:0]  REG_RESET [0:NUM_REGS-1] = '{
      8'h11, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
      8'h00, 8'h00, 8'hE2, 8'hE4, 8'hE8, 8'hE0};

   localparam logic [1:0]  HOST_TX         = 2'h0;
   localparam logic [1:0]  HOST_CMD        = 2'h1;
   localparam logic [1:0]  HOST_STATUS     = 2'h2;
   localparam logic [1:0]  HOST_RX         = 2'h3;
   localparam int          CMD_START       = 0;
   localparam int          CMD_WRITE       = 1;
   localparam int          CMD_READ        = 2;
   localparam int          CMD_NACK        = 3;
   localparam int          CMD_STOP        = 4;
endpackage

// ### lcia_if.sv
// Purpose: Two-wire link between bus controller and LED driver target
// Assumes: Open-drain wires with pull-ups, modelled by the enables
// Notes:   Only the controller drives the clock wire
`timescale 1ns/1ps
interface lcia_if;
   logic scl_o_ctrl;
   logic scl_oe_ctrl;
   logic sda_o_ctrl;
   logic sda_oe_ctrl;
   logic sda_o_tgt;
   logic sda_oe_tgt;
   logic scl;
   logic sda;

   assign scl = scl_oe_ctrl ? scl_o_ctrl : 1'b1;
   assign sda = (sda_oe_ctrl ? sda_o_ctrl : 1'b1) & (sda_oe_tgt ? sda_o_tgt : 1'b1);

   modport target     (input scl, input sda, output sda_o_tgt, output sda_oe_tgt);
   modport controller (input scl, input sda, output scl_o_ctrl, output scl_oe_ctrl,
                       output sda_o_ctrl, output sda_oe_ctrl);
endinterface

// ### lcia_ptr_step.sv
// Purpose: Next register pointer after one data byte
// Assumes: Pointer never above the last register
// Notes:   Reserved option codes have the enable clear and hold the pointer
`timescale 1ns/1ps
module lcia_ptr_step
   import lcia_pkg::*;
(
   input  wire logic [3:0] ptr_in,     // Current pointer
   input  wire logic [2:0] option_in,  // Increment option field
   output logic      [3:0] ptr_out     // Pointer for next byte
);
   logic [3:0] first;
   logic [3:0] last;

   always_comb begin
      unique case (option_in)
         OPT_BRIGHT: begin
            first = BRIGHT_FIRST;
            last  = BRIGHT_LAST;
         end
         OPT_GROUPREG: begin
            first = GROUPREG_FIRST;
            last  = GROUPREG_LAST;
         end
         OPT_BOTH: begin
            first = BRIGHT_FIRST;
            last  = GROUPREG_LAST;
         end
         default: begin
            first = PTR_FIRST;
            last  = PTR_LAST;
         end
      endcase
      if (!option_in[INC_EN_POS]) begin
         ptr_out = ptr_in;
      end else if (ptr_in == last) begin
         ptr_out = first;
      end else if (ptr_in == PTR_LAST) begin
         ptr_out = PTR_FIRST;
      end else begin
         ptr_out = ptr_in + 4'h1;
      end
   end
endmodule

// ### lcia_ctrl.sv
// Purpose: Controller end: byte-level bus master driven by a register port
// Assumes: Target never stretches the clock
// Notes:   Bus clock is a quarter-period divider of clk_in
`timescale 1ns/1ps
module lcia_ctrl
   import lcia_pkg::*;
(
   input  wire logic       clk_in,         // System clock
   input  wire logic       rst_b_in,       // Async reset, low
   lcia_if.controller      bus,            // Link wires
   input  wire logic [1:0] cmd_addr_in,    // Register offset
   input  wire logic [7:0] cmd_wdata_in,   // Write data
   input  wire logic       cmd_wr_in,      // Write strobe
   input  wire logic       cmd_rd_in,      // Read strobe
   output logic      [7:0] cmd_rdata_out   // Read data, next cycle
);
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} lcia_host_state_e;

   lcia_host_state_e st_r;
   logic [7:0]       q_r;
   logic [1:0]       phase_r;
   logic [3:0]       bit_r;
   logic [4:0]       cmd_r;
   logic [7:0]       tx_r;
   logic [7:0]       rx_r;
   logic             nack_r;
   logic             scl_oe_r;
   logic             sda_oe_r;
   logic [1:0]       sda_sync_r;
   logic             tick;

   assign bus.scl_o_ctrl  = 1'b0;
   assign bus.sda_o_ctrl  = 1'b0;
   assign bus.scl_oe_ctrl = scl_oe_r;
   assign bus.sda_oe_ctrl = sda_oe_r;
   assign tick            = (q_r == SCL_QUARTER_CYC - 8'h01);

   function automatic lcia_host_state_e step_of(input logic [4:0] c);
      if (c[CMD_START]) begin
         return H_START;
      end else if (c[CMD_WRITE] || c[CMD_READ]) begin
         return H_BIT;
      end else if (c[CMD_STOP]) begin
         return H_STOP;
      end
      return H_IDLE;
   endfunction

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sda_sync_r <= 2'h3;
      end else begin
         sda_sync_r <= {sda_sync_r[0], bus.sda};
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q_r <= 8'h00;
      end else if (st_r == H_IDLE || tick) begin
         q_r <= 8'h00;
      end else begin
         q_r <= q_r + 8'h01;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_r <= 8'h00;
      end else if (cmd_wr_in && cmd_addr_in == HOST_TX) begin
         tx_r <= cmd_wdata_in;
      end else if (st_r == H_BIT && tick && phase_r == 2'h3 && bit_r != 4'h8) begin
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r     <= H_IDLE;
         phase_r  <= 2'h0;
         bit_r    <= 4'h0;
         cmd_r    <= 5'h00;
         rx_r     <= 8'h00;
         nack_r   <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (st_r == H_IDLE) begin
         phase_r <= 2'h0;
         bit_r   <= 4'h0;
         if (cmd_wr_in && cmd_addr_in == HOST_CMD) begin
            cmd_r <= cmd_wdata_in[4:0];
            st_r  <= step_of(cmd_wdata_in[4:0]);
         end
      end else if (tick) begin
         phase_r <= phase_r + 2'h1;
         unique case (st_r)
            H_START: begin
               unique case (phase_r)
                  2'h0: sda_oe_r <= 1'b0;
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: sda_oe_r <= 1'b1;
                  2'h3: begin
                     scl_oe_r <= 1'b1;
                     cmd_r[CMD_START] <= 1'b0;
                     st_r <= step_of(cmd_r & ~(5'h01 << CMD_START));
                  end
               endcase
            end
            H_BIT: begin
               unique case (phase_r)
                  2'h0: begin
                     if (bit_r == 4'h8) begin
                        sda_oe_r <= cmd_r[CMD_READ] & ~cmd_r[CMD_NACK];
                     end else begin
                        sda_oe_r <= cmd_r[CMD_WRITE] & ~tx_r[7];
                     end
                  end
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: begin
                     if (bit_r == 4'h8) begin
                        if (cmd_r[CMD_WRITE]) begin
                           nack_r <= sda_sync_r[1];
                        end
                     end else if (cmd_r[CMD_READ]) begin
                        rx_r <= {rx_r[6:0], sda_sync_r[1]};
                     end
                  end
                  2'h3: begin
                     scl_oe_r <= 1'b1;
                     if (bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        cmd_r[CMD_WRITE] <= 1'b0;
                        cmd_r[CMD_READ]  <= 1'b0;
                        st_r <= cmd_r[CMD_STOP] ? H_STOP : H_IDLE;
                     end else begin
                        bit_r <= bit_r + 4'h1;
                     end
                  end
               endcase
            end
            H_STOP: begin
               unique case (phase_r)
                  2'h0: sda_oe_r <= 1'b1;
                  2'h1: scl_oe_r <= 1'b0;
                  2'h2: sda_oe_r <= 1'b0;
                  2'h3: begin
                     cmd_r <= 5'h00;
                     st_r  <= H_IDLE;
                  end
               endcase
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cmd_rdata_out <= 8'h00;
      end else if (cmd_rd_in) begin
         unique case (cmd_addr_in)
            HOST_TX:     cmd_rdata_out <= tx_r;
            HOST_CMD:    cmd_rdata_out <= {3'h0, cmd_r};
            HOST_STATUS: cmd_rdata_out <= {6'h00, nack_r, st_r != H_IDLE};
            HOST_RX:     cmd_rdata_out <= rx_r;
         endcase
      end
   end
endmodule

// ### lcia_checker.sv
// Purpose: Assertions on the link wires and target outputs
// Assumes: One clock domain, reset async active low
// Notes:   Instantiated beside the link, no bind
`timescale 1ns/1ps
module lcia_checker (
   input wire logic       clk_in,              // Clock
   input wire logic       rst_b_in,            // Reset
   input wire logic       scl,                 // Clock wire
   input wire logic       sda_oe_tgt,          // Target pulls data
   input wire logic       reg_wr_pulse_out,    // Byte written
   input wire logic [3:0] reg_wr_index_out,    // Its index
   input wire logic [7:0] control_byte_out,    // Control
   input wire logic       transfer_active_out  // START seen, not ignored
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   sequence s_quiet;
      (!reg_wr_pulse_out) [*8];
   endsequence
   sequence s_to_rise;
      ##[1:300] $rose(scl);
   endsequence
   a_rst_idle: assert property ($rose(rst_b_in) |-> !sda_oe_tgt && control_byte_out == 8'h00)
      else $error("target busy after reset");
   a_wr_pace: assert property (reg_wr_pulse_out |=> s_quiet)
      else $error("write pulses too close");
   a_wr_range: assert property (reg_wr_pulse_out |-> reg_wr_index_out <= 4'hC)
      else $error("write index beyond last register");
   a_opt_kept: assert property (reg_wr_pulse_out |-> $stable(control_byte_out[7:5]))
      else $error("option bits moved on a data byte");
   a_sda_edge: assert property ($changed(sda_oe_tgt) |-> !scl)
      else $error("target moved data while clock high");
   a_ack_hold: assert property ($rose(sda_oe_tgt) |-> sda_oe_tgt throughout s_to_rise)
      else $error("target let go before clock rise");
   a_wr_active: assert property (reg_wr_pulse_out |-> transfer_active_out)
      else $error("write outside addressed transfer");
   a_ctl_scope: assert property ($changed(control_byte_out) |-> transfer_active_out)
      else $error("control changed while idle");
   a_scl_high: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
endmodule

// ### lcia_tb.sv
// Purpose: Controller and target joined, driven through the command port
// Assumes: Select pins high except in one address test, regular byte C6h
// Notes:   Every byte costs about 3600 clocks, so scenarios are few
`timescale 1ns/1ps
module lcia_tb;
   import lcia_pkg::*;
   logic       clk_in = 1'b0;
   logic       rst_b_in = 1'b0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [1:0] adr = 2'h0;
   logic [7:0] wd = 8'h00;
   logic [7:0] rdata;
   logic [7:0] ctl;
   logic [3:0] idx;
   logic [7:0] wdat;
   logic [1:0] pins = 2'h3;
   logic       pulse;
   logic       software_reset_call;
   logic       act;
   logic       nk;
   int         errors = 0;
   int         total_checks = 0;
   int         cyc = 0;
   int         nrst = 0;
   always #12.5 clk_in = ~clk_in;
   lcia_if lcia_if_i ();
   lcia_ctrl lcia_ctrl_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus(lcia_if_i), .cmd_addr_in(adr),
      .cmd_wdata_in(wd), .cmd_wr_in(wr), .cmd_rd_in(rd), .cmd_rdata_out(rdata));
   lcia_target lcia_target_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus(lcia_if_i),
      .address_select_pin_0_in(pins[0]), .address_select_pin_1_in(pins[1]), .reg_wr_pulse_out(pulse),
      .reg_wr_index_out(idx), .reg_wr_data_out(wdat), .control_byte_out(ctl),
      .software_reset_call_out(software_reset_call), .transfer_active_out(act));
   lcia_checker lcia_checker_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .scl(lcia_if_i.scl),
      .sda_oe_tgt(lcia_if_i.sda_oe_tgt), .reg_wr_pulse_out(pulse), .reg_wr_index_out(idx),
      .control_byte_out(ctl), .transfer_active_out(act));
   task automatic give_verdict;
      if (errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (software_reset_call === 1'b1)
         nrst <= nrst + 1;
      if (cyc == 100000) begin
         errors = errors + 1;
         $display("CHECK FAILED %0t timeout", $time);
         give_verdict();
      end
   end
   task automatic put(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_in);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   task automatic get(input logic [1:0] a);
      @(posedge clk_in);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
   endtask
   // Busy is polled at most 3000 times, so a stuck controller ends in a counted error
   task automatic op(input logic [7:0] c, input logic [7:0] t, output logic n);
      put(HOST_TX, t);
      put(HOST_CMD, c);
      repeat (3) @(posedge clk_in);
      for (int i = 0; i < 3000; i++) begin
         get(HOST_STATUS);
         if (rdata[0] === 1'b0)
            break;
      end
      if (rdata[0] !== 1'b0) begin
         errors = errors + 1;
         $display("CHECK FAILED %0t controller stuck busy", $time);
      end
      n = rdata[1];
   endtask
   task automatic call(input logic [7:0] a, input logic e);
      op(8'h03, a, nk);
      check({7'h00, nk}, {7'h00, e});
   endtask
   task automatic run(input logic [7:0] c, input logic [3:0] i0, input logic [3:0] i1);
      call(8'hC6, 1'b0);
      op(8'h02, c, nk);
      check(ctl, c);
      op(8'h02, 8'h5A, nk);
      check({4'h0, idx}, {4'h0, i0});
      check(wdat, 8'h5A);
      // No STOP: the next address byte follows a repeated START
      op(8'h02, 8'hA5, nk);
      check({4'h0, idx}, {4'h0, i1});
      check({5'h00, ctl[7:5]}, {5'h00, c[7:5]});
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      rst_b_in <= 1'b1;
      get(HOST_STATUS);
      check(rdata, 8'h00);
      check(ctl, CTRL_RESET);
      // Refused addresses need no STOP, the next START restarts matching
      call(8'hE2, 1'b1);
      call(8'h06, 1'b0);
      check(8'(nrst), 8'h01);
      call(8'h07, 1'b1);
      @(posedge clk_in);
      pins <= 2'h2;
      call(8'hC4, 1'b0);
      @(posedge clk_in);
      pins <= 2'h3;
      run(8'h05, 4'h5, 4'h5);
      run(8'hA5, 4'h5, 4'h2);
      run(8'hC7, 4'h7, 4'h6);
      run(8'hE7, 4'h7, 4'h2);
      call(8'hE0, 1'b0);
      op(8'h02, 8'h8C, nk);
      check(ctl, 8'h8C);
      op(8'h02, 8'hAA, nk);
      check({4'h0, idx}, 8'h0C);
      // Enables sub-call 1 and keeps the group call on
      op(8'h12, 8'h09, nk);
      check({4'h0, idx}, 8'h00);
      call(8'hE3, 1'b0);
      // Reads register 1, master NACK, then STOP
      op(8'h1C, 8'h00, nk);
      get(HOST_RX);
      check(rdata, REG_RESET[1]);
      check(ctl, 8'h82);
      give_verdict();
   end
endmodule
